// File: design/pcvc_defs.svh
/*
 * constants for the parameter-channel value codec and handshake:
 * format codes, response codes, frame field values, reset values.
 * assumes it is included once per compilation unit by its bare name.
 */
`ifndef PCVC_DEFS_SVH
`define PCVC_DEFS_SVH

`define PCVC_FMT_ELAPSED 8'h0D
`define PCVC_FMT_NORM16 8'h71
`define PCVC_FMT_BITSTR 8'h73
`define PCVC_FMT_TC16 8'h76
`define PCVC_FMT_TC32 8'h77
`define PCVC_FMT_FRAC 8'h78
`define PCVC_FMT_ERROR 8'h44
`define PCVC_REQ_READ 8'h01
`define PCVC_REQ_WRITE 8'h02
`define PCVC_RSP_READ_ERR 8'h81
`define PCVC_RSP_WRITE_ERR 8'h82
`define PCVC_PNU_SCAN_TIME 16'h03C2
`define PCVC_NORM_ONE 16'h4000
`define PCVC_FRAC_SHIFT 14
`define PCVC_TC16_MAX 32'h0000_7FFF
`define PCVC_SCAN_TIME_RST 32'h0000_0001
`define PCVC_ERR_BAD_PNU 32'h0000_0000
`define PCVC_ERR_RANGE 32'h0000_0002
`define PCVC_ERR_TYPE 32'h0000_0005
`define PCVC_PROC_CYCLES 8'h04

`endif

// File: design/pcvc_pkg.sv
/*
 * types shared by both ends of the parameter channel.
 * assumes pcvc_defs.svh is on the include path.
 */
`default_nettype none
package pcvc_pkg;
	typedef enum logic [1:0] {
		PCVC_WR_NONE = 2'h0,
		PCVC_WR_ACK = 2'h1,
		PCVC_WR_NAK = 2'h2
	} pcvc_wr_rsp_t;
	typedef enum logic [2:0] {
		PCVC_RD_NONE = 3'h0,
		PCVC_RD_NAK = 3'h1,
		PCVC_RD_CHAN_ERR = 3'h2,
		PCVC_RD_EMPTY = 3'h3,
		PCVC_RD_DATA = 3'h4
	} pcvc_rd_rsp_t;
	typedef enum logic [1:0] {
		PCVC_JOB_IDLE = 2'b00,
		PCVC_JOB_PENDING = 2'b01,
		PCVC_JOB_COMPLETE = 2'b11
	} pcvc_job_t;
endpackage
`default_nettype wire

// File: design/pcvc_if.sv
/*
 * link between the gateway end and the device end of the parameter channel.
 * assumes both ends run on the same clk_sys.
 */
`default_nettype none
interface pcvc_if;
	import pcvc_pkg::*;
	logic wr_req;
	logic [7:0] req_ref;
	logic [7:0] req_id;
	logic [7:0] obj_id;
	logic [15:0] parameter_number;
	logic [7:0] fmt;
	logic [31:0] value;
	logic rd_req;
	logic wr_rsp_valid;
	pcvc_wr_rsp_t wr_rsp;
	logic [7:0] wr_err;
	logic rd_rsp_valid;
	pcvc_rd_rsp_t rd_rsp;
	logic [7:0] rsp_ref;
	logic [7:0] rsp_id;
	logic [7:0] rsp_obj_id;
	logic [7:0] rsp_fmt;
	logic [31:0] rsp_value;
	modport master (output wr_req, req_ref, req_id, obj_id, parameter_number, fmt, value, rd_req,
		input wr_rsp_valid, wr_rsp, wr_err, rd_rsp_valid, rd_rsp, rsp_ref, rsp_id, rsp_obj_id, rsp_fmt,
		rsp_value);
	modport device (input wr_req, req_ref, req_id, obj_id, parameter_number, fmt, value, rd_req,
		output wr_rsp_valid, wr_rsp, wr_err, rd_rsp_valid, rd_rsp, rsp_ref, rsp_id, rsp_obj_id, rsp_fmt,
		rsp_value);
endinterface
`default_nettype wire

// File: design/pcvc_codec.sv
/*
 * value codec: checks a raw value against its format and scales time
 * constants by the base scan time; also decodes the normalized form.
 * assumes base_scan_time is non-zero and in the caller's time unit.
 */
`default_nettype none
`include "pcvc_defs.svh"
module pcvc_codec (
	input wire logic [7:0] fmt,
	input wire logic [31:0] raw,
	input wire logic [31:0] base_scan_time,
	output logic fmt_ok,
	output logic range_ok,
	output logic [63:0] time_scaled,
	output logic norm_negative,
	output logic [15:0] norm_magnitude,
	output logic [15:0] flags
);
	import pcvc_pkg::*;

	function automatic logic [63:0] scale(input logic [31:0] i, input logic [31:0] ta);
		scale = 64'(i) * 64'(ta);
	endfunction

	always_comb begin
		fmt_ok = 1'b1;
		range_ok = 1'b1;
		time_scaled = 64'h0;
		case (fmt)
			`PCVC_FMT_ELAPSED, `PCVC_FMT_TC32: begin
				time_scaled = scale(raw, base_scan_time);
			end
			`PCVC_FMT_TC16: begin
				range_ok = (raw <= `PCVC_TC16_MAX);
				time_scaled = scale(raw, base_scan_time);
			end
			`PCVC_FMT_FRAC: begin
				// sixteen-bit raw keeps the result under four times the base time
				range_ok = (raw[31:16] == 16'h0);
				time_scaled = scale(raw, base_scan_time) >> `PCVC_FRAC_SHIFT;
			end
			`PCVC_FMT_NORM16, `PCVC_FMT_BITSTR: begin
				range_ok = (raw[31:16] == 16'h0);
			end
			default: begin
				fmt_ok = 1'b0;
			end
		endcase
	end

	// raw 0x4000 is one hundred percent; 0x8000 is the -200 percent floor
	assign norm_negative = raw[15];
	assign norm_magnitude = raw[15] ? 16'(~raw[15:0] + 16'h1) : raw[15:0];
	// first octet on the wire holds flags 15..8, second 7..0
	assign flags = {raw[15:8], raw[7:0]};
endmodule
`default_nettype wire

// File: design/pcvc_device.sv
/*
 * device end: accepts one job at a time, answers write requests at once,
 * answers polls negatively until the job completes, then the final answer.
 * assumes the master holds request fields stable while wr_req is high.
 */
`default_nettype none
`include "pcvc_defs.svh"
module pcvc_device (
	input wire logic clk_sys,
	input wire logic reset,
	pcvc_if.device link,
	input wire logic dev_reachable,
	input wire logic [15:0] pnu_limit,
	output logic [31:0] base_scan_time,
	output logic [15:0] param_pnu,
	output logic [31:0] param_value,
	output logic param_write
);
	import pcvc_pkg::*;

	pcvc_job_t job_reg;
	logic job_is_write_reg;
	logic [7:0] ref_reg;
	logic [7:0] obj_reg;
	logic [7:0] fmt_reg;
	logic [31:0] val_reg;
	logic [31:0] err_reg;
	logic chan_err_reg;
	logic [7:0] count_reg;
	logic [31:0] scan_time_reg;
	logic [31:0] store_reg [0:7];
	logic fmt_ok;
	logic range_ok;
	logic accept;
	logic pnu_bad;

	pcvc_codec codec (
		.fmt(link.fmt),
		.raw(link.value),
		.base_scan_time(scan_time_reg),
		.fmt_ok(fmt_ok),
		.range_ok(range_ok),
		.time_scaled(),
		.norm_negative(),
		.norm_magnitude(),
		.flags()
	);

	assign accept = link.wr_req && (job_reg == PCVC_JOB_IDLE);
	assign pnu_bad = (link.parameter_number >= pnu_limit) && (link.parameter_number != `PCVC_PNU_SCAN_TIME);

	// write response: ack when the frame is taken and the device is reachable
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			link.wr_rsp_valid <= 1'b0;
			link.wr_rsp <= PCVC_WR_NONE;
			link.wr_err <= 8'h0;
		end else begin
			link.wr_rsp_valid <= link.wr_req;
			if (!link.wr_req) begin
				link.wr_rsp <= PCVC_WR_NONE;
				link.wr_err <= 8'h0;
			end else if (!accept || !dev_reachable) begin
				link.wr_rsp <= PCVC_WR_NAK;
				link.wr_err <= 8'h01;
			end else begin
				link.wr_rsp <= PCVC_WR_ACK;
				link.wr_err <= 8'h0;
			end
		end
	end

	// job tracking: only a single job may be outstanding
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			job_reg <= PCVC_JOB_IDLE;
			count_reg <= 8'h0;
		end else begin
			case (job_reg)
				PCVC_JOB_IDLE: begin
					if (accept && dev_reachable) begin
						job_reg <= PCVC_JOB_PENDING;
						count_reg <= `PCVC_PROC_CYCLES;
					end
				end
				PCVC_JOB_PENDING: begin
					if (count_reg == 8'h1) begin
						job_reg <= PCVC_JOB_COMPLETE;
					end
					count_reg <= count_reg - 8'h1;
				end
				PCVC_JOB_COMPLETE: begin
					if (link.rd_req && dev_reachable) begin
						job_reg <= PCVC_JOB_IDLE;
					end
				end
				default: begin
					job_reg <= PCVC_JOB_IDLE;
				end
			endcase
		end
	end

	// capture of the request and evaluation of the outcome
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			job_is_write_reg <= 1'b0;
			ref_reg <= 8'h0;
			obj_reg <= 8'h0;
			fmt_reg <= 8'h0;
			val_reg <= 32'h0;
			err_reg <= 32'h0;
			chan_err_reg <= 1'b0;
		end else if (accept && dev_reachable) begin
			job_is_write_reg <= (link.req_id == `PCVC_REQ_WRITE);
			ref_reg <= link.req_ref;
			obj_reg <= link.obj_id;
			fmt_reg <= link.fmt;
			val_reg <= link.value;
			if (pnu_bad) begin
				chan_err_reg <= 1'b1;
				err_reg <= `PCVC_ERR_BAD_PNU;
			end else if (link.req_id == `PCVC_REQ_WRITE && !fmt_ok) begin
				chan_err_reg <= 1'b1;
				err_reg <= `PCVC_ERR_TYPE;
			end else if (link.req_id == `PCVC_REQ_WRITE && !range_ok) begin
				chan_err_reg <= 1'b1;
				err_reg <= `PCVC_ERR_RANGE;
			end else begin
				chan_err_reg <= 1'b0;
				err_reg <= 32'h0;
			end
		end
	end

	// parameter store; a non-zero write to the sampling-time entry sets the base scan time
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			scan_time_reg <= `PCVC_SCAN_TIME_RST;
			param_write <= 1'b0;
			param_pnu <= 16'h0;
			param_value <= 32'h0;
		end else begin
			param_write <= 1'b0;
			if (job_reg == PCVC_JOB_PENDING && count_reg == 8'h1 && job_is_write_reg && !chan_err_reg) begin
				param_write <= 1'b1;
				param_pnu <= link.parameter_number;
				param_value <= val_reg;
				if (link.parameter_number == `PCVC_PNU_SCAN_TIME && val_reg != 32'h0) begin
					scan_time_reg <= val_reg;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (job_reg == PCVC_JOB_PENDING && count_reg == 8'h1 && job_is_write_reg && !chan_err_reg) begin
			store_reg[link.parameter_number[2:0]] <= val_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			base_scan_time <= `PCVC_SCAN_TIME_RST;
		end else begin
			base_scan_time <= scan_time_reg;
		end
	end

	// read response, one cycle after each poll
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			link.rd_rsp_valid <= 1'b0;
			link.rd_rsp <= PCVC_RD_NONE;
			link.rsp_ref <= 8'h0;
			link.rsp_id <= 8'h0;
			link.rsp_obj_id <= 8'h0;
			link.rsp_fmt <= 8'h0;
			link.rsp_value <= 32'h0;
		end else begin
			link.rd_rsp_valid <= link.rd_req;
			link.rsp_ref <= ref_reg;
			link.rsp_obj_id <= obj_reg;
			link.rsp_id <= job_is_write_reg ? `PCVC_REQ_WRITE : `PCVC_REQ_READ;
			link.rsp_fmt <= 8'h0;
			link.rsp_value <= 32'h0;
			if (!link.rd_req) begin
				link.rd_rsp <= PCVC_RD_NONE;
			end else if (!dev_reachable || job_reg != PCVC_JOB_COMPLETE) begin
				link.rd_rsp <= PCVC_RD_NAK;
			end else if (chan_err_reg) begin
				link.rd_rsp <= PCVC_RD_CHAN_ERR;
				link.rsp_id <= job_is_write_reg ? `PCVC_RSP_WRITE_ERR : `PCVC_RSP_READ_ERR;
				link.rsp_fmt <= `PCVC_FMT_ERROR;
				link.rsp_value <= err_reg;
			end else if (job_is_write_reg) begin
				link.rd_rsp <= PCVC_RD_EMPTY;
			end else begin
				link.rd_rsp <= PCVC_RD_DATA;
				link.rsp_fmt <= fmt_reg;
				link.rsp_value <= (link.parameter_number == `PCVC_PNU_SCAN_TIME) ? scan_time_reg : store_reg[link.parameter_number[2:0]];
			end
		end
	end
endmodule
`default_nettype wire

// File: design/pcvc_master.sv
/*
 * gateway end: sends one request, waits for the write response, then, if it is an ack, polls
 * until a final read response arrives and hands it to the user.
 * assumes the user holds job fields while job_start is high.
 */
`default_nettype none
`include "pcvc_defs.svh"
module pcvc_master (
	input wire logic clk_sys,
	input wire logic reset,
	pcvc_if.master link,
	input wire logic job_start,
	input wire logic job_write,
	input wire logic [15:0] job_pnu,
	input wire logic [7:0] job_fmt,
	input wire logic [31:0] job_value,
	output logic job_busy,
	output logic job_done,
	output logic job_failed,
	output pcvc_pkg::pcvc_rd_rsp_t job_rsp,
	output logic [31:0] job_result
);
	import pcvc_pkg::*;

	typedef enum logic [1:0] {
		PCVC_M_IDLE = 2'b00,
		PCVC_M_WAIT_WR = 2'b01,
		PCVC_M_POLL = 2'b11,
		PCVC_M_WAIT_RD = 2'b10
	} pcvc_mstate_t;

	pcvc_mstate_t state_reg;
	logic [7:0] ref_reg;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= PCVC_M_IDLE;
			ref_reg <= 8'h0;
			link.wr_req <= 1'b0;
			link.rd_req <= 1'b0;
			link.req_ref <= 8'h0;
			link.req_id <= 8'h0;
			link.obj_id <= 8'h0;
			link.parameter_number <= 16'h0;
			link.fmt <= 8'h0;
			link.value <= 32'h0;
			job_busy <= 1'b0;
			job_done <= 1'b0;
			job_failed <= 1'b0;
			job_rsp <= PCVC_RD_NONE;
			job_result <= 32'h0;
		end else begin
			link.wr_req <= 1'b0;
			link.rd_req <= 1'b0;
			job_done <= 1'b0;
			case (state_reg)
				PCVC_M_IDLE: begin
					job_busy <= job_start;
					if (job_start) begin
						// references run 1..255 and skip zero
						ref_reg <= (ref_reg == 8'hFF) ? 8'h01 : 8'(ref_reg + 8'h1);
						link.req_ref <= (ref_reg == 8'hFF) ? 8'h01 : 8'(ref_reg + 8'h1);
						link.req_id <= job_write ? `PCVC_REQ_WRITE : `PCVC_REQ_READ;
						link.parameter_number <= job_pnu;
						link.fmt <= job_fmt;
						link.value <= job_value;
						link.wr_req <= 1'b1;
						state_reg <= PCVC_M_WAIT_WR;
					end
				end
				PCVC_M_WAIT_WR: begin
					if (link.wr_rsp_valid) begin
						if (link.wr_rsp == PCVC_WR_ACK) begin
							state_reg <= PCVC_M_POLL;
						end else begin
							job_done <= 1'b1;
							job_failed <= 1'b1;
							job_busy <= 1'b0;
							state_reg <= PCVC_M_IDLE;
						end
					end
				end
				PCVC_M_POLL: begin
					link.rd_req <= 1'b1;
					state_reg <= PCVC_M_WAIT_RD;
				end
				PCVC_M_WAIT_RD: begin
					if (link.rd_rsp_valid) begin
						if (link.rd_rsp == PCVC_RD_NAK) begin
							state_reg <= PCVC_M_POLL;
						end else begin
							job_done <= 1'b1;
							job_failed <= (link.rd_rsp == PCVC_RD_CHAN_ERR);
							job_rsp <= link.rd_rsp;
							job_result <= link.rsp_value;
							job_busy <= 1'b0;
							state_reg <= PCVC_M_IDLE;
						end
					end
				end
				default: begin
					state_reg <= PCVC_M_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: testbench/pcvc_link_props.sv
/*
 * concurrent checks on the link between the gateway end and the device end.
 * assumes it is instantiated beside the link that joins the two design ends.
 */
`default_nettype none
`include "pcvc_defs.svh"
module pcvc_link_props (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic wr_req,
	input wire logic [7:0] req_ref,
	input wire logic [7:0] req_id,
	input wire logic [7:0] fmt,
	input wire logic rd_req,
	input wire logic wr_rsp_valid,
	input wire pcvc_pkg::pcvc_wr_rsp_t wr_rsp,
	input wire logic [7:0] wr_err,
	input wire logic rd_rsp_valid,
	input wire pcvc_pkg::pcvc_rd_rsp_t rd_rsp,
	input wire logic [7:0] rsp_ref,
	input wire logic [7:0] rsp_id,
	input wire logic [7:0] rsp_fmt
);
	import pcvc_pkg::*;
	logic acked_reg;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// a job stays open from its ack until a final poll answer arrives
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			acked_reg <= 1'b0;
		end else if (wr_rsp_valid && wr_rsp == PCVC_WR_ACK) begin
			acked_reg <= 1'b1;
		end else if (rd_rsp_valid && rd_rsp != PCVC_RD_NAK) begin
			acked_reg <= 1'b0;
		end
	end
	a_wr_rsp_timely: assert property (wr_req |=> wr_rsp_valid ##1 !wr_rsp_valid)
		else $error("write response missing or too long");
	a_wr_rsp_caused: assert property (wr_rsp_valid |-> $past(wr_req))
		else $error("write response without request");
	a_ack_no_err: assert property (wr_rsp_valid && wr_rsp == PCVC_WR_ACK |-> wr_err == 8'h00)
		else $error("positive write response carries an error");
	a_nak_has_err: assert property (wr_rsp_valid && wr_rsp == PCVC_WR_NAK |-> wr_err != 8'h00)
		else $error("negative write response without error");
	a_poll_after_ack: assert property (rd_req |-> acked_reg)
		else $error("poll sent without an acknowledged job");
	a_poll_answered: assert property (rd_req |=> rd_rsp_valid)
		else $error("poll not answered");
	a_early_poll_nak: assert property ((wr_rsp_valid && wr_rsp == PCVC_WR_ACK) ##2 rd_req |=>
		rd_rsp == PCVC_RD_NAK) else $error("poll during processing not refused");
	a_chan_err_frame: assert property (rd_rsp_valid && rd_rsp == PCVC_RD_CHAN_ERR |-> rsp_fmt == `PCVC_FMT_ERROR &&
		rsp_id == (req_id == `PCVC_REQ_WRITE ? `PCVC_RSP_WRITE_ERR : `PCVC_RSP_READ_ERR))
		else $error("channel error frame malformed");
	a_ref_echoed: assert property (rd_rsp_valid && rd_rsp != PCVC_RD_NAK |-> rsp_ref == req_ref)
		else $error("request reference not echoed");
	a_empty_after_write: assert property (rd_rsp_valid && rd_rsp == PCVC_RD_EMPTY |-> req_id == `PCVC_REQ_WRITE)
		else $error("empty answer for a read job");
	a_data_after_read: assert property (rd_rsp_valid && rd_rsp == PCVC_RD_DATA |->
		req_id == `PCVC_REQ_READ && rsp_fmt == fmt) else $error("data answer malformed");
endmodule
`default_nettype wire

// File: testbench/param_channel_value_codec_handshake_tb_top.sv
/*
 * self-checking bench: gateway end and device end joined by one link, a second
 * device driven directly by the bench for refused requests; the codec is watched
 * inside the device end while write jobs carry its cases.
 * assumes the design package, header and link are compiled first.
 */
`default_nettype none
`include "pcvc_defs.svh"
module param_channel_value_codec_handshake_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pcvc_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic dev_reachable = 1'b1;
	logic [15:0] pnu_limit = 16'h0100;
	logic job_start = 1'b0;
	logic job_write = 1'b0;
	logic [15:0] job_pnu = 16'h0000;
	logic [7:0] job_fmt = 8'h00;
	logic [31:0] job_value = 32'h0000_0000;
	logic job_busy, job_done, job_failed, param_write;
	pcvc_rd_rsp_t job_rsp;
	logic [31:0] job_result, base_scan_time, param_value;
	logic [15:0] param_pnu;
	logic c_range_ok, c_neg;
	logic [63:0] c_time;
	logic [15:0] c_mag, c_flags;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	pcvc_if if_a ();
	pcvc_if if_b ();
	pcvc_master u_pcvc_master (.clk_sys(clk_sys), .reset(reset), .link(if_a), .job_start(job_start),
		.job_write(job_write), .job_pnu(job_pnu), .job_fmt(job_fmt), .job_value(job_value), .job_busy(job_busy),
		.job_done(job_done), .job_failed(job_failed), .job_rsp(job_rsp), .job_result(job_result));
	pcvc_device u_pcvc_device (.clk_sys(clk_sys), .reset(reset), .link(if_a), .dev_reachable(dev_reachable),
		.pnu_limit(pnu_limit), .base_scan_time(base_scan_time), .param_pnu(param_pnu),
		.param_value(param_value), .param_write(param_write));
	pcvc_device u_pcvc_device_b (.clk_sys(clk_sys), .reset(reset), .link(if_b), .dev_reachable(dev_reachable),
		.pnu_limit(pnu_limit), .base_scan_time(), .param_pnu(), .param_value(), .param_write());
	// codec results never leave the device end, so they are watched where it computes them
	assign c_range_ok = u_pcvc_device.codec.range_ok;
	assign c_neg = u_pcvc_device.codec.norm_negative;
	assign c_mag = u_pcvc_device.codec.norm_magnitude;
	assign c_time = u_pcvc_device.codec.time_scaled;
	assign c_flags = u_pcvc_device.codec.flags;
	pcvc_link_props u_pcvc_link_props (.clk_sys(clk_sys), .reset(reset), .wr_req(if_a.wr_req),
		.req_ref(if_a.req_ref), .req_id(if_a.req_id), .fmt(if_a.fmt), .rd_req(if_a.rd_req),
		.wr_rsp_valid(if_a.wr_rsp_valid), .wr_rsp(if_a.wr_rsp), .wr_err(if_a.wr_err),
		.rd_rsp_valid(if_a.rd_rsp_valid), .rd_rsp(if_a.rd_rsp), .rsp_ref(if_a.rsp_ref),
		.rsp_id(if_a.rsp_id), .rsp_fmt(if_a.rsp_fmt));
	always #2 clk_sys = ~clk_sys;
	task automatic final_report();
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// the whole run needs a few hundred cycles; the ceiling leaves wide margin
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 4000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic run_job(input logic wr, input logic [15:0] p, input logic [7:0] f, input logic [31:0] v);
		int n;
		n = 0;
		@(negedge clk_sys);
		job_start = 1'b1;
		job_write = wr;
		job_pnu = p;
		job_fmt = f;
		job_value = v;
		@(negedge clk_sys);
		job_start = 1'b0;
		check(job_busy, 1'b1);
		while (job_done !== 1'b1 && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		check(job_done, 1'b1);
	endtask
	// the master holds the job fields on the link after the job, so the codec keeps showing them
	task automatic codec_one(input logic [7:0] f, input logic [31:0] r);
		run_job(1'b1, 16'h0005, f, r);
	endtask
	// runs after the base scan time has been set to 5
	task automatic t_codec();
		codec_one(`PCVC_FMT_NORM16, 32'h0000_C000);
		check({c_neg, c_mag}, {1'b1, 16'h4000});
		codec_one(`PCVC_FMT_NORM16, 32'h0000_4000);
		check({c_neg, c_mag}, {1'b0, 16'h4000});
		codec_one(`PCVC_FMT_NORM16, 32'h0000_8000);
		check({c_neg, c_mag, c_range_ok}, {1'b1, 16'h8000, 1'b1});
		codec_one(`PCVC_FMT_BITSTR, 32'h0000_A55A);
		check(c_flags, 16'hA55A);
		codec_one(`PCVC_FMT_FRAC, 32'h0000_7FFF);
		check(c_time, 64'h9);
		codec_one(`PCVC_FMT_FRAC, 32'h0000_4000);
		check(c_time, 64'h5);
		codec_one(`PCVC_FMT_TC16, 32'h0000_7FFF);
		check({c_range_ok, c_time[47:0]}, {1'b1, 48'h2_7FFB});
		codec_one(`PCVC_FMT_TC16, 32'h0000_8000);
		check(c_range_ok, 1'b0);
		check({job_rsp, job_result}, {PCVC_RD_CHAN_ERR, `PCVC_ERR_RANGE});
		codec_one(`PCVC_FMT_TC32, 32'hFFFF_FFFF);
		check(c_time, 64'h4_FFFF_FFFB);
	endtask
	task automatic t_scan_time();
		check(base_scan_time, 32'h1);
		run_job(1'b1, `PCVC_PNU_SCAN_TIME, `PCVC_FMT_ELAPSED, 32'h5);
		check(base_scan_time, 32'h5);
		run_job(1'b0, `PCVC_PNU_SCAN_TIME, `PCVC_FMT_ELAPSED, 32'h0);
		check(job_result, 32'h5);
	endtask
	task automatic t_store();
		logic [31:0] fv;
		logic [7:0] ff;
		logic [15:0] pn;
		for (int i = 0; i < 2; i++) begin
			fv = i ? 32'h0000_A55A : 32'h0000_8000;
			ff = i ? `PCVC_FMT_BITSTR : `PCVC_FMT_NORM16;
			pn = i ? 16'h0004 : 16'h0003;
			run_job(1'b1, pn, ff, fv);
			check({job_failed, job_rsp}, {1'b0, PCVC_RD_EMPTY});
			check({param_pnu, param_value}, {pn, fv});
			run_job(1'b0, pn, ff, 32'h0);
			check({job_rsp, job_result}, {PCVC_RD_DATA, fv});
		end
	endtask
	task automatic t_chan_err();
		logic [15:0] p;
		logic [7:0] f;
		logic [31:0] e;
		for (int i = 0; i < 3; i++) begin
			p = (i == 1) ? 16'h0200 : 16'h0005;
			f = (i == 2) ? 8'hFF : `PCVC_FMT_NORM16;
			e = (i == 0) ? `PCVC_ERR_RANGE : ((i == 1) ? `PCVC_ERR_BAD_PNU : `PCVC_ERR_TYPE);
			run_job(1'b1, p, f, (i == 0) ? 32'h0001_0000 : 32'h0000_0010);
			check({job_rsp, job_result}, {PCVC_RD_CHAN_ERR, e});
		end
		run_job(1'b0, 16'h0200, `PCVC_FMT_NORM16, 32'h0);
		check({job_rsp, job_result}, {PCVC_RD_CHAN_ERR, `PCVC_ERR_BAD_PNU});
	endtask
	task automatic t_unreachable();
		@(negedge clk_sys);
		dev_reachable = 1'b0;
		run_job(1'b1, 16'h0003, `PCVC_FMT_NORM16, 32'h1);
		check(job_failed, 1'b1);
		dev_reachable = 1'b1;
	endtask
	// one request on the second link; the answer stands only in the cycle after it, so it is looked at there
	task automatic b_req(input logic wr);
		@(negedge clk_sys);
		if_b.wr_req = wr;
		if_b.rd_req = !wr;
		@(negedge clk_sys);
		check(wr ? if_b.wr_rsp_valid : if_b.rd_rsp_valid, 1'b1);
		if_b.wr_req = 1'b0;
		if_b.rd_req = 1'b0;
	endtask
	task automatic t_refusal();
		b_req(1'b1);
		check(if_b.wr_rsp, PCVC_WR_ACK);
		b_req(1'b0);
		check(if_b.rd_rsp, PCVC_RD_NAK);
		b_req(1'b1);
		check(if_b.wr_rsp, PCVC_WR_NAK);
		b_req(1'b0);
		check({if_b.rd_rsp, if_b.rsp_ref}, {PCVC_RD_EMPTY, 8'hFF});
		b_req(1'b1);
		check(if_b.wr_rsp, PCVC_WR_ACK);
	endtask
	initial begin
		if_b.wr_req = 1'b0;
		if_b.rd_req = 1'b0;
		if_b.req_ref = 8'hFF;
		if_b.req_id = `PCVC_REQ_WRITE;
		if_b.obj_id = 8'h00;
		if_b.parameter_number = 16'h0001;
		if_b.fmt = `PCVC_FMT_NORM16;
		if_b.value = 32'h0000_0010;
		repeat (3) @(negedge clk_sys);
		reset = 1'b0;
		t_scan_time();
		t_codec();
		t_store();
		t_chan_err();
		t_unreachable();
		t_refusal();
		final_report();
	end
endmodule
`default_nettype wire
